// >>> wdtss_top.sv
// Watchdog timer with sleep wake-up, AHB-Lite register slave
// Operation
// - Any device reset returns the counter to zero and the prescale field to 01011.
// - A kick instruction from the core restarts the count from zero.
// - Entering sleep clears the count, which goes on counting if the mode allows.
// - Leaving sleep clears the count again, whatever woke the core.
// - Any write to the control register clears the count as well as storing data.
// - A timeout during sleep wakes the core instead of requesting a reset.
// - A timeout during sleep drives the timeout and power-down flags low.
// - A timeout during sleep also drives the watchdog reset flag low.
// - Control bit 7 picks the crystal time base when one, the RC time base when zero.
// - Prescale bits 5:1 set ratio 1:32 at code zero, doubling per step up to 1:8388608.
// - Prescale codes above 10010 act as the 1:32 ratio.
// - After reset the prescale field holds 01011, a 1:65536 ratio.
// - The software enable bit counts only in mode 01, where one runs and zero stops.
// - Nominal periods hold for the RC time base and scale with the crystal.
// - A timeout while awake requests a device reset.
// - Mode 11 always runs, 10 runs awake only, 01 follows software, 00 never runs.
`default_nettype none
`timescale 1ns/10ps
`include "wdtss_consts.svh"
module wdtss_top #(
  parameter int CNT_W = 23
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Core events
  input wire logic kick_instruction,
  input wire logic sleep_enter,
  input wire logic sleep_exit,
  // Time bases
  input wire logic low_freq_rc_clock,
  input wire logic crystal_32k_clock,
  // Results
  output logic wdt_reset_req,
  output logic wake_req,
  output wdtss_pkg::wdtss_flags_t flags,
  output logic irq
);
  import wdtss_pkg::*;

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [1:0] tb_sync;
  logic [1:0] tb_prev_q;
  logic tick;
  wdtss_aphase_t ap_q;
  logic ap_take;
  logic wr_now;
  logic rd_now;
  logic [7:0] ctrl_q;
  logic [1:0] mode_q;
  logic [1:0] isr_q;
  logic [1:0] isr_d;
  logic [1:0] imask_q;
  logic sleep_q;
  logic en;
  logic clr;
  logic tmo;
  logic tmo_sleep;
  logic tmo_awake;
  logic [CNT_W-1:0] cnt;

  // Elaboration check
  if (CNT_W < 23) begin : g_chk
    $error("wdtss_top: CNT_W too small");
  end

  // Address decode helper
  function automatic logic is_reg(input wdtss_aphase_t a, input logic [11:0] off);
    return a.hit && (a.addr == off);
  endfunction

  // ----------------------------------------
  // Time base
  // ----------------------------------------
  // Pin clocks pass two flip-flops first
  wdtss_sync #(.W(2)) u_sync (
    .clk(hclk),
    .rst_n(hresetn),
    .d({crystal_32k_clock, low_freq_rc_clock}),
    .q(tb_sync)
  );

  // Rising edges of both sources
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tb_prev_q <= 2'h0;
    end else begin
      tb_prev_q <= tb_sync;
    end
  end

  // Source choice, ratios are in ticks of whichever runs
  assign tick = ctrl_q[`WDTSS_CTRL_CS] ? (tb_sync[1] && !tb_prev_q[1])
                                       : (tb_sync[0] && !tb_prev_q[0]);

  // ----------------------------------------
  // Bus slave
  // ----------------------------------------
  assign ap_take = hsel && htrans[1] && hready;
  assign wr_now = ap_q.wr;
  assign rd_now = ap_q.rd && !hreadyout;

  // Address phase capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_q <= '0;
    end else begin
      ap_q.addr <= haddr[11:0];
      ap_q.hit <= ap_take && (haddr[31:12] == 20'h00000);
      ap_q.wr <= ap_take && hwrite;
      ap_q.rd <= ap_take && !hwrite;
    end
  end

  // One wait state on reads, writes complete at once
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
    end else begin
      hreadyout <= !(ap_take && !hwrite);
    end
  end

  // Read data sampled in the wait cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (rd_now) begin
      if (is_reg(ap_q, `WDTSS_OFF_CTRL)) begin
        hrdata <= {24'h000000, ctrl_q};
      end else if (is_reg(ap_q, `WDTSS_OFF_FLAGS)) begin
        hrdata <= {27'h0000000, en, sleep_q, flags};
      end else if (is_reg(ap_q, `WDTSS_OFF_CFG)) begin
        hrdata <= {30'h00000000, mode_q};
      end else if (is_reg(ap_q, `WDTSS_OFF_ISTAT)) begin
        hrdata <= {30'h00000000, isr_q};
      end else if (is_reg(ap_q, `WDTSS_OFF_IMASK)) begin
        hrdata <= {30'h00000000, imask_q};
      end else begin
        hrdata <= 32'h00000000;
      end
    end
  end

  // Always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  // Control register, reserved bit kept zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= `WDTSS_CTRL_RST;
    end else if (wr_now && is_reg(ap_q, `WDTSS_OFF_CTRL)) begin
      ctrl_q <= hwdata[7:0] & 8'hBF;
    end
  end

  // Mode register and interrupt mask
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_q <= `WDTSS_MODE_RST;
      imask_q <= 2'h0;
    end else if (wr_now) begin
      if (is_reg(ap_q, `WDTSS_OFF_CFG)) begin
        mode_q <= hwdata[1:0];
      end
      if (is_reg(ap_q, `WDTSS_OFF_IMASK)) begin
        imask_q <= hwdata[1:0];
      end
    end
  end

  // ----------------------------------------
  // Sleep state and enable
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sleep_q <= 1'b0;
    end else if (sleep_exit || tmo_sleep) begin
      sleep_q <= 1'b0;
    end else if (sleep_enter) begin
      sleep_q <= 1'b1;
    end
  end

  // Mode table
  always_comb begin
    unique case (mode_q)
      `WDTSS_MODE_ON: en = 1'b1;
      `WDTSS_MODE_AWAKE: en = !sleep_q;
      `WDTSS_MODE_SW: en = ctrl_q[`WDTSS_CTRL_SEN];
      `WDTSS_MODE_OFF: en = 1'b0;
    endcase
  end

  // Every clearing event restarts the count
  assign clr = kick_instruction
             || sleep_enter
             || sleep_exit
             || (wr_now && is_reg(ap_q, `WDTSS_OFF_CTRL));

  // ----------------------------------------
  // Counter
  // ----------------------------------------
  wdtss_count #(.CNT_W(CNT_W)) u_count (
    .clk(hclk),
    .rst_n(hresetn),
    .clr(clr),
    .run(en),
    .tick(tick),
    .ps(ctrl_q[`WDTSS_CTRL_PS_HI:`WDTSS_CTRL_PS_LO]),
    .cnt(cnt),
    .tmo(tmo)
  );

  assign tmo_sleep = tmo && sleep_q;
  assign tmo_awake = tmo && !sleep_q;

  // ----------------------------------------
  // Results
  // ----------------------------------------
  // Reset request awake, wake-up in sleep
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wdt_reset_req <= 1'b0;
      wake_req <= 1'b0;
    end else begin
      wdt_reset_req <= tmo_awake;
      wake_req <= tmo_sleep;
    end
  end

  // Flags, hardware clears win over software sets
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags <= 3'h7;
    end else begin
      if (wr_now && is_reg(ap_q, `WDTSS_OFF_FLAGS) && hwdata[`WDTSS_FLAGS_WATCHDOG_RESET_FLAG_N_SET]) begin
        flags.watchdog_reset_flag_n_n <= 1'b1;
      end
      if (kick_instruction) begin
        flags.to_n <= 1'b1;
        flags.pd_n <= 1'b1;
      end
      if (sleep_enter) begin
        flags.to_n <= 1'b1;
        flags.pd_n <= 1'b0;
      end
      if (tmo_sleep) begin
        flags.to_n <= 1'b0;
        flags.pd_n <= 1'b0;
        flags.watchdog_reset_flag_n_n <= 1'b0;
      end
      if (tmo_awake) begin
        flags.to_n <= 1'b0;
        flags.watchdog_reset_flag_n_n <= 1'b0;
      end
    end
  end

  // Sticky events, read clears, set wins
  assign isr_d = ((rd_now && is_reg(ap_q, `WDTSS_OFF_ISTAT)) ? 2'h0 : isr_q) | {tmo_sleep, tmo_awake};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      isr_q <= 2'h0;
      irq <= 1'b0;
    end else begin
      isr_q <= isr_d;
      irq <= |(isr_q & imask_q);
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  a_reset_count_zero: assert property (@(posedge hclk) disable iff (1'b0) !hresetn |-> cnt == '0)
    else $error("count not zero in reset");
  a_kick_clears: assert property (kick_instruction |=> cnt == '0)
    else $error("kick did not clear count");
  a_sleep_entry_clears: assert property (sleep_enter |=> cnt == '0 && sleep_q)
    else $error("sleep entry did not clear count");
  a_wake_clears: assert property (sleep_exit |=> cnt == '0 && !sleep_q)
    else $error("wake did not clear count");
  a_ctrl_write_clears: assert property (ap_q.wr && is_reg(ap_q, `WDTSS_OFF_CTRL) |=> cnt == '0
      && ctrl_q == ($past(hwdata[7:0]) & 8'hBF))
    else $error("control write did not clear count");
  a_sleep_tmo_wakes: assert property (tmo && sleep_q |=> wake_req && !wdt_reset_req ##1 !wake_req)
    else $error("sleep timeout did not wake");
  a_sleep_tmo_flags: assert property (tmo && sleep_q |=> !flags.to_n && !flags.pd_n)
    else $error("sleep timeout flags wrong");
  a_sleep_tmo_watchdog_reset_flag_n: assert property (tmo && sleep_q |=> !flags.watchdog_reset_flag_n_n && isr_q[1])
    else $error("sleep timeout reset flag wrong");
  a_reserved_ps_min: assert property (ctrl_q[5:1] > `WDTSS_PS_MAX && $stable(ctrl_q) |-> cnt < CNT_W'(32))
    else $error("reserved prescale exceeded minimum ratio");
  a_ps_reset_value: assert property (@(posedge hclk) disable iff (1'b0)
      !hresetn |-> ctrl_q[5:1] == `WDTSS_PS_RST)
    else $error("prescale reset value wrong");
  a_sen_ignored: assert property (mode_q == `WDTSS_MODE_OFF && !clr |=> cnt == $past(cnt) && !tmo)
    else $error("counter moved while off");
  a_awake_tmo_reset: assert property (tmo && !sleep_q |=> wdt_reset_req && !wake_req)
    else $error("awake timeout did not request reset");
  a_hold_disabled: assert property (!en && !clr |=> cnt == $past(cnt))
    else $error("counter moved while disabled");
  a_read_answer: assert property (ap_take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");

  c_awake_reset: cover property (tmo_awake ##1 wdt_reset_req);
  c_sleep_wake: cover property (sleep_enter ##[1:1000] wake_req);
  c_sw_mode_run: cover property (mode_q == `WDTSS_MODE_SW && en && tick);
  c_irq_raised: cover property (irq && imask_q != 2'h0);
endmodule
`default_nettype wire

// >>> wdtss_consts.svh
// Constants of the watchdog timer with sleep wake-up
`ifndef WDTSS_CONSTS_SVH
`define WDTSS_CONSTS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define WDTSS_OFF_CTRL 12'h18C
`define WDTSS_OFF_FLAGS 12'h190
`define WDTSS_OFF_CFG 12'h194
`define WDTSS_OFF_ISTAT 12'h198
`define WDTSS_OFF_IMASK 12'h19C

// ----------------------------------------
// Field positions
// ----------------------------------------
`define WDTSS_CTRL_CS 7
`define WDTSS_CTRL_RSVD 6
`define WDTSS_CTRL_PS_HI 5
`define WDTSS_CTRL_PS_LO 1
`define WDTSS_CTRL_SEN 0
`define WDTSS_FLAGS_WATCHDOG_RESET_FLAG_N_SET 2

// ----------------------------------------
// Reset values
// ----------------------------------------
`define WDTSS_CTRL_RST 8'h16
`define WDTSS_MODE_RST 2'h3

// ----------------------------------------
// Modes and prescale limits
// ----------------------------------------
`define WDTSS_MODE_ON 2'h3
`define WDTSS_MODE_AWAKE 2'h2
`define WDTSS_MODE_SW 2'h1
`define WDTSS_MODE_OFF 2'h0
`define WDTSS_PS_BASE 5'h05
`define WDTSS_PS_MAX 5'h12
`define WDTSS_PS_RST 5'h0B

`endif

// >>> wdtss_pkg.sv
// Types and helpers of the watchdog timer
`default_nettype none
`include "wdtss_consts.svh"
package wdtss_pkg;

  // Captured bus address phase
  typedef struct packed {
    logic [11:0] addr;
    logic hit;
    logic wr;
    logic rd;
  } wdtss_aphase_t;

  // Status flags, all active low
  typedef struct packed {
    logic watchdog_reset_flag_n_n;
    logic pd_n;
    logic to_n;
  } wdtss_flags_t;

  // Reserved prescale codes fall back to the shortest ratio
  function automatic logic [4:0] wdtss_eff_ps(input logic [4:0] ps);
    return (ps > `WDTSS_PS_MAX) ? 5'h00 : ps;
  endfunction

endpackage
`default_nettype wire

// >>> wdtss_sync.sv
// Two-stage synchroniser for asynchronous levels
`default_nettype none
`timescale 1ns/10ps
module wdtss_sync #(
  parameter int W = 2
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;

  // Elaboration check
  if (W < 1) begin : g_chk
    $error("wdtss_sync: W must be positive");
  end

  // First stage feeds only the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule
`default_nettype wire

// >>> wdtss_count.sv
// Watchdog counter with programmable terminal count
`default_nettype none
`timescale 1ns/10ps
`include "wdtss_consts.svh"
module wdtss_count #(
  parameter int CNT_W = 23
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic clr,
  input wire logic run,
  input wire logic tick,
  input wire logic [4:0] ps,
  // Results
  output logic [CNT_W-1:0] cnt,
  output logic tmo
);
  import wdtss_pkg::*;

  logic [4:0] shift;
  logic [CNT_W-1:0] last;

  // Elaboration check
  if (CNT_W < 23) begin : g_chk
    $error("wdtss_count: CNT_W too small for longest ratio");
  end

  // Terminal count for the selected ratio
  assign shift = `WDTSS_PS_BASE + wdtss_eff_ps(ps);
  assign last = (CNT_W'(1) << shift) - CNT_W'(1);

  // Count time-base ticks, clear on request, hold when stopped
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= '0;
    end else if (clr) begin
      cnt <= '0;
    end else if (run && tick) begin
      cnt <= (cnt == last) ? '0 : cnt + CNT_W'(1);
    end
  end

  // One-cycle timeout pulse
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tmo <= 1'b0;
    end else begin
      tmo <= !clr && run && tick && (cnt == last);
    end
  end
endmodule
`default_nettype wire

// >>> wdtss_core_model.sv
// Behavioural core model issuing kick, sleep and wake events
`default_nettype none
`timescale 1ns/10ps
module wdtss_core_model (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Bench commands
  input wire logic cmd_kick,
  input wire logic cmd_sleep,
  input wire logic cmd_wake,
  // Watchdog answer
  input wire logic wake_req,
  // Events to the watchdog
  output logic kick_instruction,
  output logic sleep_enter,
  output logic sleep_exit,
  output logic asleep
);
  // One-cycle event pulses; a sleeping core cannot kick
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      kick_instruction <= 1'b0;
      sleep_enter <= 1'b0;
      sleep_exit <= 1'b0;
    end else begin
      kick_instruction <= cmd_kick && !asleep;
      sleep_enter <= cmd_sleep && !asleep;
      sleep_exit <= asleep && (cmd_wake || wake_req);
    end
  end
  // Core sleep state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      asleep <= 1'b0;
    end else if (sleep_exit) begin
      asleep <= 1'b0;
    end else if (sleep_enter) begin
      asleep <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// >>> tb_top.sv
// Self-checking bench of the watchdog timer
`default_nettype none
`timescale 1ns/10ps
`include "wdtss_consts.svh"
module tb_top;
  import wdtss_pkg::*;
  logic hclk = 1'b0, hresetn = 1'b1, hsel = 1'b0, hwrite = 1'b0, rc = 1'b0, xt = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2, cmd = 3'h0;
  logic hready, hreadyout, hresp, kick, s_in, s_out, asleep, rst_req, wake, irq;
  logic [15:0] rs = 16'h000D;
  wdtss_flags_t flags;
  int err_total = 0, cmp_count = 0;
  assign hready = hreadyout;
  always #12.5 hclk = ~hclk;
  always #50 rc = ~rc;
  always #75 xt = ~xt;
  wdtss_top u_wdtss_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .kick_instruction(kick), .sleep_enter(s_in),
    .sleep_exit(s_out), .low_freq_rc_clock(rc), .crystal_32k_clock(xt), .wdt_reset_req(rst_req),
    .wake_req(wake), .flags(flags), .irq(irq));
  wdtss_core_model u_wdtss_core_model (.hclk(hclk), .hresetn(hresetn), .cmd_kick(cmd[0]),
    .cmd_sleep(cmd[1]), .cmd_wake(cmd[2]), .wake_req(wake), .kick_instruction(kick),
    .sleep_enter(s_in), .sleep_exit(s_out), .asleep(asleep));
  // ----------------------------------------
  // Checking and reporting
  // ----------------------------------------
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // Time-base edges expected before a timeout
  function automatic int exp_ticks(input logic [4:0] ps);
    return 1 << ((ps > 5'h12) ? 5 : 5 + int'(ps));
  endfunction
  // ----------------------------------------
  // Bus and event drivers
  // ----------------------------------------
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 40);
    if (hreadyout !== 1'b1) begin
      chk(1'b0, 1'b1, "bus hang");
      wrap_up();
    end
  endtask
  task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {20'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    wait_rdy();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    wait_rdy();
    q = hrdata;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(a, 1'b1, d, q);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp, input string msg);
    logic [31:0] q;
    bus(a, 1'b0, 32'h0, q);
    chk(q, exp, msg);
    chk(hresp, 1'b0, "response not OKAY");
  endtask
  task automatic ev(input logic [2:0] c);
    @(posedge hclk);
    cmd <= c;
    @(posedge hclk);
    cmd <= 3'h0;
  endtask
  // No timeout pulse for a number of cycles
  task automatic quiet(input int c);
    int p;
    p = 0;
    repeat (c) begin
      @(posedge hclk);
      #1;
      if (rst_req !== 1'b0 || wake !== 1'b0) p++;
    end
    chk(p, 0, "unexpected timeout");
  endtask
  // Timeout pulse within the window of the tick count
  task automatic wait_tmo(input int ticks, input int per, input logic slp);
    int n;
    n = 0;
    while (rst_req !== 1'b1 && wake !== 1'b1 && n < ticks * per + 40) begin
      @(posedge hclk);
      #1;
      n++;
    end
    chk(n >= (ticks - 1) * per && n <= ticks * per + 12, 1'b1, "timeout moment");
    chk(wake, slp, "wake pulse");
    chk(rst_req, !slp, "reset pulse");
    if (n >= ticks * per + 40) wrap_up();
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [4:0] ps;
    // Falling edge before the first clock so every flop resets at once
    #1 hresetn <= 1'b0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (3) @(posedge hclk);
    rdc(`WDTSS_OFF_CTRL, 32'h16, "control reset");
    rdc(`WDTSS_OFF_CFG, 32'h3, "mode reset");
    chk(flags, 3'h7, "flags reset");
    rdc(12'h1A0, 32'h0, "unmapped read");
    for (int i = 0; i < 4; i++) begin
      rs = lfsr(rs);
      wr(`WDTSS_OFF_CTRL, {24'h0, rs[7:0]});
      rdc(`WDTSS_OFF_CTRL, {24'h0, rs[7:0] & 8'hBF}, "control readback");
    end
    $display("registers done");
    wr(`WDTSS_OFF_IMASK, 32'h1);
    rdc(`WDTSS_OFF_IMASK, 32'h1, "mask readback");
    // Each control write cleared the count, so no timeout yet
    rdc(`WDTSS_OFF_ISTAT, 32'h0, "status after readback");
    for (int i = 0; i < 3; i++) begin
      ps = 5'(i);
      wr(`WDTSS_OFF_CTRL, {26'h0, ps, 1'b0});
      wait_tmo(exp_ticks(ps), 4, 1'b0);
      chk({flags.watchdog_reset_flag_n_n, flags.to_n}, 2'h0, "awake timeout flags");
    end
    for (int i = 0; i < 3; i++) begin
      rs = lfsr(rs);
      ps = 5'h13 + 5'(rs % 13);
      wr(`WDTSS_OFF_CTRL, {26'h0, ps, 1'b0});
      wait_tmo(32, 4, 1'b0);
    end
    wr(`WDTSS_OFF_CTRL, 32'h80);
    wait_tmo(32, 6, 1'b0);
    chk(irq, 1'b1, "irq raised");
    rdc(`WDTSS_OFF_ISTAT, 32'h1, "status awake bit");
    quiet(3);
    chk(irq, 1'b0, "irq after clear");
    $display("timeouts done");
    wr(`WDTSS_OFF_CTRL, 32'h0);
    for (int i = 0; i < 3; i++) begin
      quiet(100);
      ev(3'h1);
    end
    quiet(3);
    chk({flags.pd_n, flags.to_n}, 2'h3, "kick flags");
    wait_tmo(32, 4, 1'b0);
    wr(`WDTSS_OFF_CTRL, 32'h0);
    quiet(100);
    wr(`WDTSS_OFF_CTRL, 32'h0);
    wait_tmo(32, 4, 1'b0);
    $display("clears done");
    wr(`WDTSS_OFF_CTRL, 32'h0);
    quiet(60);
    ev(3'h2);
    quiet(3);
    chk({flags.pd_n, flags.to_n}, 2'h1, "sleep entry flags");
    wait_tmo(32, 4, 1'b1);
    chk(flags, 3'h0, "sleep timeout flags");
    chk(flags.watchdog_reset_flag_n_n, 1'b0, "sleep reset flag");
    quiet(3);
    chk(asleep, 1'b0, "core woken");
    // Awake timeouts since the last status read set bit 0 as well
    rdc(`WDTSS_OFF_ISTAT, 32'h3, "status sleep bit");
    rdc(`WDTSS_OFF_FLAGS, 32'h10, "flags register after wake");
    wr(`WDTSS_OFF_FLAGS, 32'h4);
    rdc(`WDTSS_OFF_FLAGS, 32'h14, "reset flag set back");
    ev(3'h2);
    quiet(60);
    ev(3'h4);
    wait_tmo(32, 4, 1'b0);
    $display("sleep done");
    wr(`WDTSS_OFF_CFG, 32'h2);
    wr(`WDTSS_OFF_CTRL, 32'h0);
    ev(3'h2);
    quiet(300);
    ev(3'h4);
    wait_tmo(32, 4, 1'b0);
    wr(`WDTSS_OFF_CFG, 32'h1);
    wr(`WDTSS_OFF_CTRL, 32'h0);
    quiet(300);
    wr(`WDTSS_OFF_CTRL, 32'h1);
    wait_tmo(32, 4, 1'b0);
    wr(`WDTSS_OFF_CFG, 32'h0);
    wr(`WDTSS_OFF_CTRL, 32'h1);
    quiet(300);
    $display("modes done");
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (3) @(posedge hclk);
    rdc(`WDTSS_OFF_CTRL, 32'h16, "control after reset");
    chk(flags, 3'h7, "flags after reset");
    quiet(200);
    $display("reset done");
    wrap_up();
  end
endmodule
`default_nettype wire
